// ---- design/chfws_pkg.sv ----
// package for the chain fault / watchdog supervisor: constants, types
// assumes one 50 MHz core clock and a command decoder on that clock
// How it works
// R1 - idle ports: send fault status reply immediately
// R2 - one message per fault until status cleared
// R3 - busy ports: hold message until activity ends
// R4 - delayed message starts within rate-scaled limit
// R5 - pending fault: reads get fault then data
// R6 - pending fault: writes fault only, actions nothing
// R7 - zero write to fault status clears, acks
// R8 - watchdog inert when not daisy chained
// R9 - codes 1 to 63 give seconds
// R10 - top-bit codes give two-minute steps to 128
// R11 - code zero disables the watchdog
// R12 - zero code needs password, nonzero always accepted
// R13 - expiry sets flag, sleeps, halts measuring
// R14 - chained device drives alert while asleep
// R15 - expiry sends no chain fault message
// R16 - watchdog keeps counting during sleep
// R17 - only commands for this device restart watchdog
// R18 - wait for reply from device above
// R19 - reply timeout sends failure with own address
// R20 - reply kinds per command, top versus target
// R21 - target relays failure, plus data for reads
// R22 - failure reaches host within rate-scaled limit
// R23 - force chain inputs idle after each communication
// R24 - host may send all-ones bytes to recover
// R25 - alert low until all fault registers zero
// R26 - valid communication reloads full timeout
package chfws_pkg;
   // clock and timing
   localparam int CLK_HZ = 50_000_000;
   localparam int WDG_STEP_S = 1; // watchdog tick, seconds
   localparam int SEC_CYC = WDG_STEP_S * CLK_HZ;
   localparam int HOP_US = 400; // reply wait per level
   localparam int HOP_CYC = HOP_US * (CLK_HZ / 1_000_000);
   localparam int FAULT_RESP_MAX_US = 68; // at fastest chain rate
   localparam int FAIL_RESP_MAX_US = 5800; // at fastest chain rate
   // register map
   localparam logic [5:0] ADDR_FAULT_STATUS = 6'h04;
   localparam logic [5:0] ADDR_WBT = 6'h15;
   localparam logic [13:0] WBT_RESET = 14'h0000;
   localparam logic [13:0] FAULT_CLEAR = 14'h0000;
   localparam logic [5:0] WDG_PASSWORD = 6'h3a;
   // watchdog code layout
   localparam int WDG_CODE_W = 7;
   localparam int WDG_RANGE_BIT = 6;
   localparam int WDG_MIN_STEP = 2; // minutes per high step
   localparam int SEC_PER_MIN = 60;
   localparam int WDG_SEC_W = 13; // holds 128 minutes
   localparam logic [1:0] CHAIN_IDLE = 2'h1; // idle level of rx pins

   // command kinds seen by this device
   typedef enum logic [3:0] {
      CMD_READ = 4'h0, CMD_WRITE = 4'h1, CMD_SCAN = 4'h2,
      CMD_MEASURE = 4'h3, CMD_IDENTIFY = 4'h4, CMD_SLEEP = 4'h5,
      CMD_NAK = 4'h6, CMD_ACK = 4'h7, CMD_WAKEUP = 4'h8,
      CMD_BAL_EN = 4'h9, CMD_BAL_INH = 4'ha, CMD_RESET = 4'hb,
      CMD_CALC_CK = 4'hc, CMD_CHECK_CK = 4'hd, CMD_SCAN_CTL = 4'he
   } chfws_cmd_kind_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } chfws_state_t;

   // decoded command strobe
   typedef struct packed {
      logic valid; // one-cycle strobe
      logic for_me; // addressed here or broadcast
      chfws_cmd_kind_t kind;
      logic [5:0] reg_addr;
      logic [13:0] wdata;
   } chfws_cmd_t;

   // reply arriving from the device above
   typedef struct packed {
      logic ok; // normal reply seen
      logic fail; // failure message seen
      logic [3:0] fail_addr;
   } chfws_reply_t;

   // response this device must transmit downward
   typedef struct packed {
      logic valid;
      logic fault; // fault status reply first
      logic data; // then requested data
      logic ack;
      logic nak;
      logic fail;
      logic [3:0] fail_addr;
   } chfws_resp_t;

   // static position and rate
   typedef struct packed {
      logic daisy; // part of a daisy chain
      logic top;
      logic [3:0] addr;
      logic [3:0] size;
      logic [1:0] rate; // 0=500k .. 3=62.5k
   } chfws_cfg_t;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
   } chfws_sync_st_t;
endpackage

// ---- design/chfws_sync.sv ----
// two-flop synchroniser for the two daisy chain receive pins
// assumes the pins are asynchronous to core_clk_i
`timescale 1ns/100ps
`default_nettype none
module chfws_sync (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // pins and synced result
   input wire logic [1:0] pin_i,
   output logic [1:0] sync_o
);
   chfws_pkg::chfws_sync_st_t st_reg; // both stages
   chfws_pkg::chfws_sync_st_t st_next;

   // first stage feeds only the second
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pin_i;
      st_next.s2 = st_reg.s1;
   end

   // register the stages; idle level after reset
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st_reg <= {chfws_pkg::CHAIN_IDLE, chfws_pkg::CHAIN_IDLE};
      end else if (clk_en_i) begin
         st_reg <= st_next;
      end
   end

   assign sync_o = st_reg.s2;
endmodule
`default_nettype wire

// ---- design/chfws_supervisor.sv ----
// chain fault messaging, comms watchdog, reply timeout, idle recovery
// assumes a command decoder and chain receiver on core_clk_i
`timescale 1ns/100ps
`default_nettype none
module chfws_supervisor #(
   parameter int SEC_CYC = chfws_pkg::SEC_CYC, // cycles per second
   parameter int HOP_CYC = chfws_pkg::HOP_CYC // reply wait per level
) (
   // clock, reset, enable
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // position and chain rate
   input wire chfws_pkg::chfws_cfg_t cfg_i,
   // decoded commands and replies from above
   input wire chfws_pkg::chfws_cmd_t cmd_i,
   input wire chfws_pkg::chfws_reply_t reply_i,
   input wire logic chain_busy_i,
   input wire logic [1:0] chain_rx_i,
   // fault sources and setup password field
   input wire logic [13:0] fault_status_i,
   input wire logic fault_data_nz_i,
   input wire logic [5:0] setup_pwd_i,
   // responses and status
   output chfws_pkg::chfws_resp_t resp_o,
   output logic [13:0] wbt_o,
   output logic comms_timeout_fault_flag_o,
   output logic sleep_o,
   output logic meas_halt_o,
   output logic fault_n_o,
   output logic idle_restore_o,
   output logic port_flipped_o,
   output logic wait_reply_o
);
   // all state of this module
   typedef struct packed {
      chfws_pkg::chfws_state_t state;
      chfws_pkg::chfws_resp_t resp;
      logic [13:0] wbt; // watchdog_balance_timing
      logic [25:0] pre; // one-second prescaler
      logic [12:0] secs; // seconds left
      logic flag; // comms_timeout_fault_flag
      logic sleep;
      logic msg_sent; // fault message already issued
      logic clr_d; // fault status cleared last cycle
      logic busy_d;
      logic idle_restore;
      logic flipped;
      logic [23:0] wcnt; // reply wait counter
      chfws_pkg::chfws_cmd_kind_t wkind;
      logic wtarget; // waited command was for us
   } chfws_st_t;

   chfws_st_t st_reg;
   chfws_st_t st_next;
   logic [1:0] rx_sync; // synced chain rx pins

   // timeout in seconds for a watchdog code
   function automatic logic [12:0] wdg_seconds(input logic [6:0] code);
      logic [12:0] steps;
      steps = {7'h00, code[5:0]} + 13'h0001;
      if (code[chfws_pkg::WDG_RANGE_BIT]) begin // R10
         wdg_seconds = 13'(steps * 13'(chfws_pkg::WDG_MIN_STEP *
                                        chfws_pkg::SEC_PER_MIN));
      end else begin
         wdg_seconds = {7'h00, code[5:0]}; // R9
      end
   endfunction

   // commands after which this device waits for the one above
   function automatic logic cmd_waits(input chfws_pkg::chfws_cmd_kind_t k);
      unique case (k)
         chfws_pkg::CMD_READ, chfws_pkg::CMD_WRITE, chfws_pkg::CMD_ACK,
         chfws_pkg::CMD_NAK, chfws_pkg::CMD_BAL_EN, chfws_pkg::CMD_BAL_INH,
         chfws_pkg::CMD_CALC_CK, chfws_pkg::CMD_CHECK_CK:
            cmd_waits = 1'b1; // R18 R20
         default:
            cmd_waits = 1'b0;
      endcase
   endfunction

   // normal reply of this device to a command
   function automatic chfws_pkg::chfws_resp_t respond(
      input chfws_pkg::chfws_cmd_kind_t k,
      input logic target,
      input logic top,
      input logic pend,
      input logic clr);
      chfws_pkg::chfws_resp_t r;
      r = '0;
      if (pend && target && !clr) begin
         // outstanding fault overrides the normal reply
         if (k == chfws_pkg::CMD_READ) begin
            r.fault = 1'b1; // R5
            r.data = 1'b1;
         end else if (k == chfws_pkg::CMD_WRITE) begin
            r.fault = 1'b1; // R6
         end
      end else begin
         unique case (k)
            chfws_pkg::CMD_READ: begin
               r.data = target; // R20
               r.ack = !target;
            end
            chfws_pkg::CMD_WRITE, chfws_pkg::CMD_ACK, chfws_pkg::CMD_NAK,
            chfws_pkg::CMD_BAL_EN, chfws_pkg::CMD_BAL_INH,
            chfws_pkg::CMD_CALC_CK, chfws_pkg::CMD_CHECK_CK,
            chfws_pkg::CMD_SCAN_CTL: begin
               r.ack = 1'b1; // R7 R20
            end
            chfws_pkg::CMD_IDENTIFY, chfws_pkg::CMD_SLEEP,
            chfws_pkg::CMD_WAKEUP: begin
               r.ack = top;
               r.nak = !top;
            end
            default: begin
               r = '0; // scan, measure, reset answer nothing
            end
         endcase
      end
      r.valid = r.fault | r.data | r.ack | r.nak;
      respond = r;
   endfunction

   // receive pins cross in from outside the clock domain
   chfws_sync u_sync (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .pin_i(chain_rx_i),
      .sync_o(rx_sync)
   );

   // next-state logic
   always_comb begin
      logic mine;
      logic clr_wr;
      logic wdg_on;
      logic fault_any;
      logic [3:0] levels;
      logic [23:0] limit;
      logic [12:0] reload;
      mine = 1'b0;
      clr_wr = 1'b0;
      wdg_on = 1'b0;
      fault_any = 1'b0;
      levels = 4'h0;
      limit = 24'h000000;
      reload = 13'h0000;
      st_next = st_reg;
      st_next.resp = '0;
      st_next.idle_restore = 1'b0;
      st_next.busy_d = chain_busy_i;

      mine = cmd_i.valid & cmd_i.for_me;
      clr_wr = mine && cmd_i.kind == chfws_pkg::CMD_WRITE &&
               cmd_i.reg_addr == chfws_pkg::ADDR_FAULT_STATUS &&
               cmd_i.wdata == chfws_pkg::FAULT_CLEAR; // R7
      st_next.clr_d = clr_wr;

      // end of activity: re-force the receive inputs idle
      if (st_reg.busy_d && !chain_busy_i) begin
         st_next.idle_restore = 1'b1; // R23
      end
      // a quiet port sitting at the wrong level looks flipped
      st_next.flipped = !chain_busy_i && rx_sync != chfws_pkg::CHAIN_IDLE;

      // timing register write; zero code guarded by password
      if (mine && cmd_i.kind == chfws_pkg::CMD_WRITE &&
          cmd_i.reg_addr == chfws_pkg::ADDR_WBT) begin
         if (cmd_i.wdata[6:0] != 7'h00 ||
             setup_pwd_i == chfws_pkg::WDG_PASSWORD) begin
            st_next.wbt = cmd_i.wdata; // R12
         end else begin
            st_next.wbt = {cmd_i.wdata[13:7], st_reg.wbt[6:0]}; // R12
         end
      end

      // sleep entry and exit by command
      if (mine && cmd_i.kind == chfws_pkg::CMD_SLEEP) begin
         st_next.sleep = 1'b1;
      end else if (mine && cmd_i.kind == chfws_pkg::CMD_WAKEUP) begin
         st_next.sleep = 1'b0;
      end

      // flag clears only once awake; expiry below wins over the clear
      if (clr_wr && !st_reg.sleep) begin
         st_next.flag = 1'b0; // R14
      end

      // watchdog: only in a chain and with a nonzero code
      wdg_on = cfg_i.daisy && st_next.wbt[6:0] != 7'h00; // R8 R11
      reload = wdg_seconds(st_next.wbt[6:0]);
      if (!wdg_on) begin
         st_next.pre = 26'h0000000;
         st_next.secs = reload;
      end else if (mine) begin
         st_next.pre = 26'h0000000; // R17
         st_next.secs = reload; // R26
      end else if (st_reg.pre == 26'(SEC_CYC - 1)) begin
         st_next.pre = 26'h0000000;
         if (st_reg.secs <= 13'h0001) begin
            // expiry; counting goes on even while asleep
            st_next.flag = 1'b1; // R13
            st_next.sleep = 1'b1; // R13 R16
            st_next.secs = reload; // R16
         end else begin
            st_next.secs = st_reg.secs - 13'h0001;
         end
      end else begin
         st_next.pre = st_reg.pre + 26'h0000001;
      end

      // fault message latch; the timeout flag is not a source here
      fault_any = |fault_status_i; // R15
      if (clr_wr) begin
         st_next.msg_sent = 1'b0; // R2 R7
      end

      // reply wait limit grows with levels above and slower rates
      levels = cfg_i.size - cfg_i.addr;
      if (levels == 4'h0) begin
         levels = 4'h1;
      end
      limit = 24'(24'(HOP_CYC) * {20'h00000, levels}) << cfg_i.rate; // R22

      unique case (st_reg.state)
         chfws_pkg::ST_IDLE: begin
            if (cmd_i.valid && cmd_waits(cmd_i.kind) && !cfg_i.top &&
                cfg_i.daisy) begin
               st_next.state = chfws_pkg::ST_WAIT; // R18
               st_next.wcnt = 24'h000000;
               st_next.wkind = cmd_i.kind;
               st_next.wtarget = cmd_i.for_me;
            end else if (cmd_i.valid && (cmd_i.for_me || cfg_i.top)) begin
               st_next.resp = respond(cmd_i.kind, cmd_i.for_me, cfg_i.top,
                                      st_reg.msg_sent, clr_wr); // R20
            end
         end
         chfws_pkg::ST_WAIT: begin
            st_next.wcnt = st_reg.wcnt + 24'h000001;
            if (reply_i.fail) begin
               st_next.state = chfws_pkg::ST_IDLE;
               if (st_reg.wtarget) begin
                  st_next.resp.valid = 1'b1; // R21
                  st_next.resp.fail = 1'b1;
                  st_next.resp.fail_addr = reply_i.fail_addr;
                  st_next.resp.data = st_reg.wkind == chfws_pkg::CMD_READ;
               end
            end else if (reply_i.ok) begin
               st_next.state = chfws_pkg::ST_IDLE;
               if (st_reg.wtarget) begin
                  st_next.resp = respond(st_reg.wkind, 1'b1, 1'b0,
                                         st_reg.msg_sent, st_reg.clr_d);
               end
            end else if (st_reg.wcnt >= limit) begin
               st_next.state = chfws_pkg::ST_IDLE;
               st_next.resp.valid = 1'b1; // R19
               st_next.resp.fail = 1'b1;
               st_next.resp.fail_addr = cfg_i.addr; // R19
            end
         end
      endcase

      // unsolicited message once ports are quiet and nothing else goes
      if (fault_any && !st_reg.msg_sent && !clr_wr && !st_reg.clr_d &&
          !chain_busy_i && !cmd_i.valid && !st_next.resp.valid) begin // R3
         st_next.resp = '0;
         st_next.resp.valid = 1'b1; // R1 R4
         st_next.resp.fault = 1'b1;
         st_next.msg_sent = 1'b1; // R2
      end
   end

   // state register with clock enable
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st_reg <= '0;
         st_reg.wbt <= chfws_pkg::WBT_RESET;
         st_reg.state <= chfws_pkg::ST_IDLE;
         st_reg.wkind <= chfws_pkg::CMD_READ;
      end else if (clk_en_i) begin
         st_reg <= st_next;
      end
   end

   // outputs; alert is combinational so it falls the cycle a fault shows
   assign resp_o = st_reg.resp;
   assign wbt_o = st_reg.wbt;
   assign comms_timeout_fault_flag_o = st_reg.flag;
   assign sleep_o = st_reg.sleep;
   assign meas_halt_o = st_reg.sleep; // R13
   assign fault_n_o = !(|fault_status_i || fault_data_nz_i ||
                        (st_reg.flag && cfg_i.daisy)); // R14 R25
   assign idle_restore_o = st_reg.idle_restore;
   assign port_flipped_o = st_reg.flipped;
   assign wait_reply_o = st_reg.state == chfws_pkg::ST_WAIT;
endmodule
`default_nettype wire

// ---- verif/chfws_monitor.sv ----
// checker on the supervisor ports: alert, watchdog, reply wait, restore
// assumes clk_en_i stays high whenever reset_i is low
`timescale 1ns/100ps
`default_nettype none
module chfws_monitor #(
   parameter int HOP_CYC = 8
) (
   // clock, reset, enable
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // inputs of the block
   input wire chfws_pkg::chfws_cfg_t cfg_i,
   input wire chfws_pkg::chfws_cmd_t cmd_i,
   input wire chfws_pkg::chfws_reply_t reply_i,
   input wire logic chain_busy_i,
   input wire logic [1:0] chain_rx_i,
   input wire logic [13:0] fault_status_i,
   input wire logic fault_data_nz_i,
   input wire logic [5:0] setup_pwd_i,
   // outputs of the block
   input wire chfws_pkg::chfws_resp_t resp_o,
   input wire logic [13:0] wbt_o,
   input wire logic comms_timeout_fault_flag_o,
   input wire logic sleep_o,
   input wire logic meas_halt_o,
   input wire logic fault_n_o,
   input wire logic idle_restore_o,
   input wire logic port_flipped_o,
   input wire logic wait_reply_o
);
   // longest reply wait: fifteen levels at the slowest rate, plus output
   localparam int WAIT_MAX = HOP_CYC * 120 + 4;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   // any live fault bit pulls the alert low at once
   property p_alert_on; (|fault_status_i) |-> !fault_n_o; endproperty
   a_alert_on: assert property (p_alert_on) else $error("alert idle");
   // alert released whenever every source is clear
   property p_alert_off; fault_status_i == 14'h0000 && !fault_data_nz_i &&
      !comms_timeout_fault_flag_o |-> fault_n_o; endproperty
   a_alert_off: assert property (p_alert_off) else $error("alert stuck");
   // a chained device asleep keeps the alert driven
   property p_sleep_alert; cfg_i.daisy && sleep_o &&
      comms_timeout_fault_flag_o |=> !sleep_o || !fault_n_o; endproperty
   a_sleep_alert: assert property (p_sleep_alert) else $error("sleep alert");
   // stand-alone device never raises the timeout flag
   property p_alone; !cfg_i.daisy && !comms_timeout_fault_flag_o |=>
      !comms_timeout_fault_flag_o; endproperty
   a_alone: assert property (p_alone) else $error("alone flag");
   // expiry means sleep and halted measurement together
   property p_expiry; $rose(comms_timeout_fault_flag_o) |->
      sleep_o && meas_halt_o; endproperty
   a_expiry: assert property (p_expiry) else $error("expiry no sleep");
   // expiry alone sends nothing on the chain
   property p_no_msg; $rose(comms_timeout_fault_flag_o) &&
      fault_status_i == 14'h0000 |=> (!resp_o.fault) [*2]; endproperty
   a_no_msg: assert property (p_no_msg) else $error("expiry message");
   // end of traffic forces the inputs idle within a cycle
   property p_restore; $fell(chain_busy_i) |-> ##[0:1] idle_restore_o;
   endproperty
   a_restore: assert property (p_restore) else $error("no restore");
   // no unsolicited message straight after a busy cycle
   property p_busy_hold; $past(chain_busy_i) && !$past(cmd_i.valid) &&
      !$past(reply_i.ok) && !$past(reply_i.fail) |-> !resp_o.fault;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy msg");
   // a failure found here carries this device's own address
   property p_fail_addr; resp_o.valid && resp_o.fail && !$past(reply_i.fail)
      |-> resp_o.fail_addr == cfg_i.addr; endproperty
   a_fail_addr: assert property (p_fail_addr) else $error("fail addr");
   // a reply wait always ends in bounded time
   property p_wait_bound; $rose(wait_reply_o) |-> ##[1:WAIT_MAX]
      !wait_reply_o; endproperty
   a_wait_bound: assert property (p_wait_bound) else $error("wait hang");
   // the reply from above ends the wait with an answer
   property p_reply_ends; wait_reply_o && reply_i.ok |=> resp_o.valid &&
      !wait_reply_o; endproperty
   a_reply_ends: assert property (p_reply_ends) else $error("no answer");
endmodule
bind chfws_supervisor chfws_monitor #(.HOP_CYC(HOP_CYC)) i_mon (
   .core_clk_i, .reset_i, .clk_en_i, .cfg_i, .cmd_i, .reply_i,
   .chain_busy_i, .chain_rx_i, .fault_status_i, .fault_data_nz_i,
   .setup_pwd_i, .resp_o, .wbt_o, .comms_timeout_fault_flag_o,
   .sleep_o, .meas_halt_o, .fault_n_o, .idle_restore_o,
   .port_flipped_o, .wait_reply_o
);
`default_nettype wire

// ---- verif/chfws_above_model.sv ----
// model of the stack device above: answers a waited command
// assumes the bench sets the answer kind before each command
`timescale 1ns/100ps
`default_nettype none
module chfws_above_model (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // wait seen below and chosen behaviour
   input wire logic wait_reply_i,
   input wire logic [1:0] mode_i, // 0 ok, 1 failure, 2 silent
   input wire logic [3:0] fail_addr_i,
   input wire logic [7:0] delay_i,
   // reply pulses toward the supervisor
   output chfws_pkg::chfws_reply_t reply_o
);
   int cnt; // cycles since the wait began
   // one pulse per wait; each field is written once per edge
   always @(negedge core_clk_i) begin
      if (reset_i || !wait_reply_i) begin
         cnt <= 0;
         reply_o <= '0;
      end else begin
         cnt <= cnt + 1;
         reply_o.ok <= cnt == int'(delay_i) && mode_i == 2'h0;
         reply_o.fail <= cnt == int'(delay_i) && mode_i == 2'h1;
         reply_o.fail_addr <= fail_addr_i;
      end
   end
endmodule
`default_nettype wire

// ---- verif/chfws_supervisor_tb_top.sv ----
// self-checking bench for the supervisor with the device above modelled
// assumes shrunk second and hop counts keep the run short
`timescale 1ns/100ps
`default_nettype none
module chfws_supervisor_tb_top;
   localparam int SEC = 20; // cycles per watchdog second
   localparam int HOP = 8; // reply wait per level
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   chfws_pkg::chfws_cfg_t cfg = '0;
   chfws_pkg::chfws_cmd_t cmd = '0;
   chfws_pkg::chfws_reply_t reply;
   chfws_pkg::chfws_resp_t resp, got;
   logic busy = 1'b0;
   logic [1:0] rx = 2'h1;
   logic [13:0] fs = 14'h0000;
   logic fnz = 1'b0;
   logic [5:0] pwd = 6'h00;
   logic [13:0] wbt;
   logic flag, slp, halt, fault_n, restore, flip, waitr;
   logic [1:0] mode = 2'h0;
   int num_errors = 0;
   int cmp_count = 0;
   int lat;
   always #10 core_clk_i = ~core_clk_i;
   chfws_supervisor #(.SEC_CYC(SEC), .HOP_CYC(HOP)) i_dut (
      .core_clk_i, .reset_i, .clk_en_i(1'b1), .cfg_i(cfg), .cmd_i(cmd),
      .reply_i(reply), .chain_busy_i(busy), .chain_rx_i(rx),
      .fault_status_i(fs), .fault_data_nz_i(fnz), .setup_pwd_i(pwd),
      .resp_o(resp), .wbt_o(wbt), .comms_timeout_fault_flag_o(flag),
      .sleep_o(slp), .meas_halt_o(halt), .fault_n_o(fault_n),
      .idle_restore_o(restore), .port_flipped_o(flip), .wait_reply_o(waitr));
   chfws_above_model i_above (.core_clk_i, .reset_i, .wait_reply_i(waitr),
      .mode_i(mode), .fail_addr_i(4'h3), .delay_i(8'h05), .reply_o(reply));
   // compare and count; unknowns never match
   task automatic check(input string name, input logic [31:0] seen,
         input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   // first new answer in max cycles; also ends any command strobe
   task automatic catch_resp(input int max);
      got = '0;
      for (lat = 1; lat <= max; lat++) begin
         @(negedge core_clk_i);
         cmd.valid <= 1'b0;
         if (resp.valid === 1'b1) begin
            got = resp;
            break;
         end
      end
   endtask
   // one-cycle command strobe, then wait for its answer
   task automatic xfer(input chfws_pkg::chfws_cmd_kind_t k, input logic me,
         input logic [5:0] a, input logic [13:0] d, input int max);
      @(negedge core_clk_i);
      cmd <= {1'b1, me, k, a, d};
      catch_resp(max);
   endtask
   task automatic wr(input logic [5:0] a, input logic [13:0] d);
      xfer(chfws_pkg::CMD_WRITE, 1'b1, a, d, 30);
   endtask
   // config changes only while reset is held
   task automatic do_reset(input logic dsy, input logic top,
         input logic [1:0] rate);
      reset_i <= 1'b1;
      cfg <= {dsy, top, 4'h1, 4'h3, rate};
      cyc(6);
      reset_i <= 1'b0;
   endtask
   // program a code, reload midway, then expect expiry and recover
   task automatic comms_timeout_code(input logic [6:0] code, input int n);
      wr(chfws_pkg::ADDR_WBT, {7'h00, code});
      cyc(n / 2);
      xfer(chfws_pkg::CMD_ACK, 1'b1, 6'h00, 14'h0000, 3);
      cyc(n - SEC - 4);
      if (n > SEC) check("flag early", flag, 1'b0);
      for (int i = 0; i < SEC + 12 && flag !== 1'b1; i++) cyc(1);
      check("flag", flag, 1'b1);
      check("asleep", {slp, halt, fault_n}, 3'b110);
      xfer(chfws_pkg::CMD_WAKEUP, 1'b1, 6'h00, 14'h0000, 3);
      check("awake", slp, 1'b0);
      pwd <= chfws_pkg::WDG_PASSWORD;
      wr(chfws_pkg::ADDR_WBT, 14'h0000);
      pwd <= 6'h00;
      wr(chfws_pkg::ADDR_FAULT_STATUS, chfws_pkg::FAULT_CLEAR);
      check("cleared", {flag, fault_n, wbt}, {2'b01, 14'h0000});
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // hang guard, well beyond the expected run
   initial begin
      cyc(40000);
      num_errors++;
      complete_run();
   end
   initial begin
      do_reset(1'b1, 1'b1, 2'h0);
      check("wbt reset", wbt, chfws_pkg::WBT_RESET);
      check("state reset", {flag, slp, waitr}, 3'b000);
      wr(chfws_pkg::ADDR_WBT, 14'h0005);
      check("write ack", got[9:4], 6'b100100);
      check("wbt", wbt, 14'h0005);
      wr(chfws_pkg::ADDR_WBT, 14'h0080);
      check("zero refused", wbt, 14'h0085);
      wr(chfws_pkg::ADDR_WBT, 14'h3fc1);
      check("nonzero kept", wbt, 14'h3fc1);
      pwd <= chfws_pkg::WDG_PASSWORD;
      wr(chfws_pkg::ADDR_WBT, 14'h0000);
      pwd <= 6'h00;
      check("zero taken", wbt, 14'h0000);
      // top answers every kind except scan, measure and reset, as a non-target
      for (int k = 0; k < 15; k++) begin
         xfer(chfws_pkg::chfws_cmd_kind_t'(4'(k)), 1'b0, 6'h00, 14'h0000, 3);
         check("top", got[9:4], 15'h77f3 >> k & 1 ? 6'b100100 : 6'h00);
      end
      fs <= 14'h0010;
      catch_resp(4);
      check("fault msg", got[9:4], 6'b110000);
      fs <= 14'h0030;
      catch_resp(30);
      check("no repeat", got[9:4], 6'h00);
      xfer(chfws_pkg::CMD_READ, 1'b1, 6'h04, 14'h0000, 4);
      check("read", got[9:4], 6'b111000);
      wr(6'h10, 14'h0001);
      check("write", got[9:4], 6'b110000);
      xfer(chfws_pkg::CMD_BAL_EN, 1'b1, 6'h00, 14'h0000, 4);
      check("action", got[9:4], 6'h00);
      fs <= 14'h0000;
      wr(chfws_pkg::ADDR_FAULT_STATUS, chfws_pkg::FAULT_CLEAR);
      check("clear ack", got[9:4], 6'b100100);
      fnz <= 1'b1;
      cyc(1);
      check("data alert", fault_n, 1'b0);
      fnz <= 1'b0;
      busy <= 1'b1;
      cyc(2);
      fs <= 14'h0001;
      catch_resp(10);
      check("held", got[9:4], 6'h00);
      busy <= 1'b0;
      catch_resp(20);
      check("late msg", got[9:4], 6'b110000);
      rx <= 2'h2;
      cyc(5);
      check("flipped", flip, 1'b1);
      rx <= 2'h1;
      fs <= 14'h0000;
      wr(chfws_pkg::ADDR_FAULT_STATUS, chfws_pkg::FAULT_CLEAR);
      cyc(3);
      check("restored", flip, 1'b0);
      comms_timeout_code(7'h01, SEC);
      comms_timeout_code(7'h3f, 63 * SEC);
      comms_timeout_code(7'h40, 120 * SEC);
      comms_timeout_code(7'h41, 240 * SEC);
      do_reset(1'b0, 1'b1, 2'h0);
      wr(chfws_pkg::ADDR_WBT, 14'h0001);
      cyc(3 * SEC);
      check("alone", {flag, fault_n}, 2'b01);
      do_reset(1'b1, 1'b0, 2'h0);
      xfer(chfws_pkg::CMD_READ, 1'b1, 6'h04, 14'h0000, 30);
      check("relay data", got[9:4], 6'b101000);
      mode <= 2'h1;
      wr(6'h10, 14'h0001);
      check("relay fail", {got[9:4], got.fail_addr}, 10'h213);
      xfer(chfws_pkg::CMD_READ, 1'b1, 6'h04, 14'h0000, 30);
      check("fail data", got[9:4], 6'b101001);
      xfer(chfws_pkg::CMD_SCAN, 1'b1, 6'h00, 14'h0000, 4);
      check("scan", {got.valid, waitr}, 2'b00);
      mode <= 2'h2;
      // silent partner at each chain rate
      for (int r = 0; r < 4; r++) begin
         do_reset(1'b1, 1'b0, 2'(r));
         xfer(chfws_pkg::CMD_ACK, 1'b1, 6'h00, 14'h0000, 200);
         check("timeout", {got[9:4], got.fail_addr}, 10'h211);
         check("limit", lat >= 16 << r && lat <= (16 << r) + 4, 1'b1);
      end
      complete_run();
   end
endmodule
`default_nettype wire
